// ===== hw/dsp_params.svh
// Purpose: constants shared by the signal-processing extension datapath
// Assumes: included by both module files of the unit, types come from dsp_pkg
// Notes: the control word layout is local to this unit
// Behaviour
// - absolute value of a word, most negative input clamps to largest positive
// - two 16-bit signed lane adds, plain or saturating; saturating 32-bit add
// - carry-setting add stores carry; carry add consumes it for 64-bit sums
// - four unsigned byte adds, saturating form clamps each lane at 255
// - mirror low 16 bits of source, upper half of result is zero
// - position branch taken when position is 32 or more, 16-bit relative target
// - signed halfword compares write condition bits 1 and 0, high and low
// - unsigned byte compares to register put four result bits at bottom
// - unsigned byte compares to control write condition bits 3 down to 0
// - halfword dot product saturated to word fraction, added or subtracted
// - unsigned byte dot product of left or right byte pair, added or subtracted
// - saturated word fraction product subtracted from accumulator
// - extract field ending at position bit, length from immediate or register
// - decrementing extracts lower position by extracted length
// - accumulator shifted right 0..31, optional rounding and word saturation
// - accumulator shifted right and saturated to signed 16 bits
// - insert field at position as lowest bit, size from insert-size field
// - indexed loads base plus index, byte zero, half sign extended, aligned
// - single lane fraction multiply accumulate, optional word fraction clamp
// - circular index: max when index zero, else index minus step
// - fill moves accumulator low half up, then writes register to low half
// - unsigned bytes times unsigned halves, each half saturated to 16 bits
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH
`define CTL_POS_LSB     0
`define CTL_POS_W       6
`define CTL_SCOUNT_LSB  6
`define CTL_SCOUNT_W    6
`define CTL_CARRY_BIT   12
`define CTL_CCOND_LSB   13
`define CTL_CCOND_W     4
`define POS_RESET       6'h00
`define SCOUNT_RESET    6'h00
`define CCOND_RESET     4'h0
`define ACC_RESET       64'h0000000000000000
`define POS_BRANCH_MIN  6'h20
`define BR_SLOT_BYTES   32'h00000004
`define Q31_MAX         32'h7FFFFFFF
`define Q31_MIN         32'h80000000
`define Q15_MAX         16'h7FFF
`define Q15_MIN         16'h8000
`define Q63_MAX         64'h7FFFFFFFFFFFFFFF
`define UBYTE_MAX       8'hFF
`define UHALF_MAX       16'hFFFF
`endif

// ===== hw/dsp_pkg.sv
// Purpose: types of the signal-processing extension datapath
// Assumes: nothing
// Notes: operation codes are abstract, the core decoder maps onto them
package dsp_pkg;
	typedef enum {
		OP_ABS_SAT, OP_PH_ADD, OP_PH_ADD_SAT, OP_W_ADD_SAT, OP_ADD_SET_C, OP_ADD_WITH_C,
		OP_QB_ADD, OP_QB_ADD_SAT, OP_BIT_REV, OP_POS_BRANCH, OP_PH_CMP, OP_QB_CMP_REG,
		OP_QB_CMP_CTL, OP_DOT_FRAC_ADD, OP_DOT_FRAC_SUB, OP_WORD_FRAC_MSUB,
		OP_DOT_BYTE_ADD_L, OP_DOT_BYTE_ADD_R, OP_DOT_BYTE_SUB_L, OP_DOT_BYTE_SUB_R,
		OP_FIELD_EXT, OP_FIELD_EXT_DEC, OP_SHX, OP_SHX_RND, OP_SHX_RND_SAT, OP_SHX_HALF,
		OP_FIELD_INS, OP_LOAD_BYTE, OP_LOAD_HALF, OP_LOAD_WORD, OP_LANE_MAC_L, OP_LANE_MAC_R,
		OP_LANE_MAC_SAT_L, OP_LANE_MAC_SAT_R, OP_CIRC_INDEX, OP_ACC_FILL, OP_BH_MUL_L,
		OP_BH_MUL_R
	} op_t;
	typedef enum {CMP_EQ, CMP_LT, CMP_LE} cmp_cond_t;
	typedef enum {SZ_BYTE, SZ_HALF, SZ_WORD} ld_size_t;
endpackage

// ===== hw/dsp_mac_unit.sv
// Purpose: accumulator arithmetic of the multiply-accumulate operations
// Assumes: combinational, the caller gates the write enable with its issue valid
// Notes: accumulation itself never saturates except in the lane clamp variants
`timescale 1ns/1ps
`include "dsp_params.svh"
module dsp_mac_unit
	import dsp_pkg::*;
(
	// operation
	input  op_t         op,
	input  logic [31:0] rs,
	input  logic [31:0] rt,
	input  logic [63:0] acc,
	// result
	output logic [63:0] acc_nxt,
	output logic        acc_we
);
	// only -1 x -1 overflows a fraction product, so it alone is clamped
	function automatic logic [31:0] q15_mul(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] p;
		p = 32'($signed(a)) * 32'($signed(b));
		if (a == `Q15_MIN && b == `Q15_MIN)
			return `Q31_MAX;
		return {p[30:0], 1'b0};
	endfunction

	function automatic logic [63:0] sat31(input logic [32:0] s);
		logic [31:0] w;
		w = (s[32] != s[31]) ? (s[32] ? `Q31_MIN : `Q31_MAX) : s[31:0];
		return {{32{w[31]}}, w};
	endfunction

	logic        [31:0] ph1, ph0, lm;
	logic        [63:0] dot, wq, bdl, bdr, lsum;
	logic signed [63:0] wp;
	logic        [15:0] pb3, pb2, pb1, pb0;

	always_comb begin
		ph1 = q15_mul(rs[31:16], rt[31:16]);
		ph0 = q15_mul(rs[15:0], rt[15:0]);
		dot = sat31({ph1[31], ph1} + {ph0[31], ph0});
		wp = 64'($signed(rs)) * 64'($signed(rt));
		wq = (rs == `Q31_MIN && rt == `Q31_MIN) ? `Q63_MAX : {wp[62:0], 1'b0};
		pb3 = {8'h00, rs[31:24]} * {8'h00, rt[31:24]};
		pb2 = {8'h00, rs[23:16]} * {8'h00, rt[23:16]};
		pb1 = {8'h00, rs[15:8]} * {8'h00, rt[15:8]};
		pb0 = {8'h00, rs[7:0]} * {8'h00, rt[7:0]};
		bdl = {47'h0, {1'b0, pb3} + {1'b0, pb2}};
		bdr = {47'h0, {1'b0, pb1} + {1'b0, pb0}};
		if (op == OP_LANE_MAC_L || op == OP_LANE_MAC_SAT_L)
			lm = q15_mul(rs[31:16], rt[31:16]);
		else
			lm = q15_mul(rs[15:0], rt[15:0]);
		lsum = acc + {{32{lm[31]}}, lm};
		acc_we = 1'b1;
		case (op)
			OP_DOT_FRAC_ADD:   acc_nxt = acc + dot;
			OP_DOT_FRAC_SUB:   acc_nxt = acc - dot;
			OP_WORD_FRAC_MSUB: acc_nxt = acc - wq;
			OP_DOT_BYTE_ADD_L: acc_nxt = acc + bdl;
			OP_DOT_BYTE_ADD_R: acc_nxt = acc + bdr;
			OP_DOT_BYTE_SUB_L: acc_nxt = acc - bdl;
			OP_DOT_BYTE_SUB_R: acc_nxt = acc - bdr;
			OP_LANE_MAC_L, OP_LANE_MAC_R: acc_nxt = lsum;
			OP_LANE_MAC_SAT_L, OP_LANE_MAC_SAT_R: begin
				if ($signed(lsum) > $signed({32'h0, `Q31_MAX}))
					acc_nxt = {32'h0, `Q31_MAX};
				else if ($signed(lsum) < $signed({32'hFFFFFFFF, `Q31_MIN}))
					acc_nxt = {32'hFFFFFFFF, `Q31_MIN};
				else
					acc_nxt = lsum;
			end
			default: begin
				acc_nxt = acc;
				acc_we = 1'b0;
			end
		endcase
	end
endmodule

// ===== hw/dsp_simd_execution_unit.sv
// Purpose: execution datapath of the signal-processing instruction extension
// Assumes: the core issues one operation per cycle and arbitrates register writes
// Notes: results appear one cycle after issue; load data returns through ld_valid
`timescale 1ns/1ps
`include "dsp_params.svh"
module dsp_simd_execution_unit
	import dsp_pkg::*;
#(
	parameter int ACC_NUM = 4
)(
	// clock and reset
	input  logic                       clk_sys,
	input  logic                       rstn,
	// issue
	input  logic                       op_valid,
	input  op_t                        op,
	input  cmp_cond_t                  cmp_cond,
	input  logic [31:0]                rs,
	input  logic [31:0]                rt,
	input  logic [4:0]                 rd_idx,
	input  logic [$clog2(ACC_NUM)-1:0] ac_sel,
	input  logic [4:0]                 imm_amt,
	input  logic                       amt_from_reg,
	input  logic [31:0]                pc,
	input  logic [15:0]                br_offset,
	// control register write
	input  logic                       ctl_wr,
	input  logic [31:0]                ctl_wr_data,
	// load return
	input  logic                       ld_valid,
	input  logic [31:0]                ld_data,
	// register file write
	output logic                       gpr_we_r,
	output logic [4:0]                 gpr_waddr_r,
	output logic [31:0]                gpr_wdata_r,
	// branch
	output logic                       br_valid_r,
	output logic                       br_taken_r,
	output logic [31:0]                br_target_r,
	// load request
	output logic                       ld_req_r,
	output logic [31:0]                ld_addr_r,
	output ld_size_t                   ld_size_r,
	output logic                       ld_align_err_r,
	// control register fields
	output logic [5:0]                 pos_r,
	output logic [5:0]                 scount_r,
	output logic                       carry_r,
	output logic [3:0]                 ccond_r,
	// accumulator zero as hi/lo pair
	output logic [31:0]                hi_r,
	output logic [31:0]                lo_r
);
	function automatic logic [15:0] sat_h(input logic [16:0] s);
		return (s[16] != s[15]) ? (s[16] ? `Q15_MIN : `Q15_MAX) : s[15:0];
	endfunction

	function automatic logic [31:0] add_ph(input logic [31:0] a, input logic [31:0] b,
	                                       input logic sat);
		logic [16:0] s;
		add_ph = 32'h0;
		for (int i = 0; i < 2; i++) begin
			s = {a[16*i+15], a[16*i+:16]} + {b[16*i+15], b[16*i+:16]};
			add_ph[16*i+:16] = sat ? sat_h(s) : s[15:0];
		end
	endfunction

	function automatic logic [31:0] add_qb(input logic [31:0] a, input logic [31:0] b,
	                                       input logic sat);
		logic [8:0] s;
		add_qb = 32'h0;
		for (int i = 0; i < 4; i++) begin
			s = {1'b0, a[8*i+:8]} + {1'b0, b[8*i+:8]};
			add_qb[8*i+:8] = (sat && s[8]) ? `UBYTE_MAX : s[7:0];
		end
	endfunction

	function automatic logic cmp_one(input cmp_cond_t c, input logic signed [16:0] a,
	                                 input logic signed [16:0] b);
		case (c)
			CMP_EQ:  return a == b;
			CMP_LT:  return a < b;
			default: return a <= b;
		endcase
	endfunction

	// shared by the register and control targets
	function automatic logic [3:0] cmp_qb(input cmp_cond_t c, input logic [31:0] a,
	                                      input logic [31:0] b);
		cmp_qb = 4'h0;
		for (int i = 0; i < 4; i++)
			cmp_qb[i] = cmp_one(c, {9'h0, a[8*i+:8]}, {9'h0, b[8*i+:8]});
	endfunction

	function automatic logic [15:0] sat_u16(input logic [23:0] p);
		return (|p[23:16]) ? `UHALF_MAX : p[15:0];
	endfunction

	logic [63:0] acc_r [ACC_NUM];
	logic [63:0] acc_cur, mac_nxt, acc_wval, ins_mask, ext_shr;
	logic        mac_we, acc_we, is_load, ld_ok;
	logic [4:0]  amt;
	logic [5:0]  fld_len, fld_lsb;
	logic [32:0] csum, wsum;
	logic [64:0] sx_sum, sx_shr;
	logic        gpr_we_nxt;
	logic [31:0] gpr_wdata_nxt, ld_addr_nxt, ld_ext;
	logic [4:0]  ld_dest_r;
	logic [7:0]  bh_hi, bh_lo;

	assign acc_cur = acc_r[ac_sel];
	assign hi_r = acc_r[0][63:32];
	assign lo_r = acc_r[0][31:0];

	dsp_mac_unit u_mac (
		.op      (op),
		.rs      (rs),
		.rt      (rt),
		.acc     (acc_cur),
		.acc_nxt (mac_nxt),
		.acc_we  (mac_we)
	);

	// operand preparation
	always_comb begin
		amt = amt_from_reg ? rs[4:0] : imm_amt;
		fld_len = {1'b0, amt} + 6'h01;
		fld_lsb = pos_r - {1'b0, amt};
		ext_shr = acc_cur >> fld_lsb;
		csum = {1'b0, rs} + {1'b0, rt} + {32'h0, (op == OP_ADD_WITH_C) & carry_r};
		wsum = {rs[31], rs} + {rt[31], rt};
		// rounding adds half an lsb of the shifted result before the shift
		sx_sum = {acc_cur[63], acc_cur};
		if ((op == OP_SHX_RND || op == OP_SHX_RND_SAT) && amt != 5'h00)
			sx_sum = sx_sum + (65'h1 << (amt - 5'h01));
		sx_shr = $signed(sx_sum) >>> amt;
		ins_mask = ((64'h1 << scount_r) - 64'h1) << pos_r;
		bh_hi = (op == OP_BH_MUL_L) ? rs[31:24] : rs[15:8];
		bh_lo = (op == OP_BH_MUL_L) ? rs[23:16] : rs[7:0];
	end

	// general register result
	always_comb begin
		gpr_we_nxt = op_valid;
		gpr_wdata_nxt = 32'h0;
		case (op)
			OP_ABS_SAT:
				gpr_wdata_nxt = (rt == `Q31_MIN) ? `Q31_MAX : (rt[31] ? ~rt + 32'h1 : rt);
			OP_PH_ADD:     gpr_wdata_nxt = add_ph(rs, rt, 1'b0);
			OP_PH_ADD_SAT: gpr_wdata_nxt = add_ph(rs, rt, 1'b1);
			OP_W_ADD_SAT:
				gpr_wdata_nxt = (wsum[32] != wsum[31]) ?
				                (wsum[32] ? `Q31_MIN : `Q31_MAX) : wsum[31:0];
			OP_ADD_SET_C, OP_ADD_WITH_C: gpr_wdata_nxt = csum[31:0];
			OP_QB_ADD:     gpr_wdata_nxt = add_qb(rs, rt, 1'b0);
			OP_QB_ADD_SAT: gpr_wdata_nxt = add_qb(rs, rt, 1'b1);
			OP_BIT_REV:    gpr_wdata_nxt = {16'h0, {<<{rt[15:0]}}};
			OP_QB_CMP_REG: gpr_wdata_nxt = {28'h0, cmp_qb(cmp_cond, rs, rt)};
			OP_FIELD_EXT, OP_FIELD_EXT_DEC:
				gpr_wdata_nxt = ext_shr[31:0] & ((32'h1 << amt) - 32'h1 | (32'h1 << amt));
			OP_SHX, OP_SHX_RND: gpr_wdata_nxt = sx_shr[31:0];
			OP_SHX_RND_SAT: begin
				if (&sx_shr[64:31] || ~|sx_shr[64:31])
					gpr_wdata_nxt = sx_shr[31:0];
				else
					gpr_wdata_nxt = sx_shr[64] ? `Q31_MIN : `Q31_MAX;
			end
			OP_SHX_HALF: begin
				if (&sx_shr[64:15] || ~|sx_shr[64:15])
					gpr_wdata_nxt = sx_shr[31:0];
				else
					gpr_wdata_nxt = sx_shr[64] ? {16'hFFFF, `Q15_MIN} : {16'h0, `Q15_MAX};
			end
			OP_FIELD_INS:
				gpr_wdata_nxt = (rt & ~ins_mask[31:0]) | (rs << pos_r) & ins_mask[31:0];
			OP_CIRC_INDEX:
				gpr_wdata_nxt = (rs == 32'h0) ? {8'h00, rt[31:8]} : rs - {24'h0, rt[7:0]};
			OP_BH_MUL_L, OP_BH_MUL_R:
				gpr_wdata_nxt = {sat_u16({16'h0000, bh_hi} * {8'h00, rt[31:16]}),
				                 sat_u16({16'h0000, bh_lo} * {8'h00, rt[15:0]})};
			default: gpr_we_nxt = 1'b0;
		endcase
	end

	// load address and the value written back on return
	always_comb begin
		ld_addr_nxt = rs + rt;
		is_load = op_valid && (op == OP_LOAD_BYTE || op == OP_LOAD_HALF || op == OP_LOAD_WORD);
		ld_ok = (op == OP_LOAD_BYTE) || (op == OP_LOAD_HALF && !ld_addr_nxt[0]) ||
		        (op == OP_LOAD_WORD && ld_addr_nxt[1:0] == 2'h0);
		case (ld_size_r)
			SZ_BYTE: ld_ext = {24'h0, ld_data[7:0]};
			SZ_HALF: ld_ext = {{16{ld_data[15]}}, ld_data[15:0]};
			default: ld_ext = ld_data;
		endcase
		acc_we = op_valid && (mac_we || op == OP_ACC_FILL);
		acc_wval = (op == OP_ACC_FILL) ? {acc_cur[31:0], rs} : mac_nxt;
	end

	// a returning load owns the write port, the core keeps issue off it that cycle
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			gpr_we_r <= 1'b0;
			gpr_waddr_r <= 5'h00;
			gpr_wdata_r <= 32'h0;
		end else if (ld_valid) begin
			gpr_we_r <= 1'b1;
			gpr_waddr_r <= ld_dest_r;
			gpr_wdata_r <= ld_ext;
		end else begin
			gpr_we_r <= gpr_we_nxt;
			gpr_waddr_r <= rd_idx;
			gpr_wdata_r <= gpr_wdata_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ld_req_r <= 1'b0;
			ld_align_err_r <= 1'b0;
			ld_addr_r <= 32'h0;
			ld_size_r <= SZ_WORD;
			ld_dest_r <= 5'h00;
		end else begin
			ld_req_r <= is_load && ld_ok;
			ld_align_err_r <= is_load && !ld_ok;
			if (is_load) begin
				ld_addr_r <= ld_addr_nxt;
				ld_dest_r <= rd_idx;
				ld_size_r <= (op == OP_LOAD_BYTE) ? SZ_BYTE :
				             (op == OP_LOAD_HALF) ? SZ_HALF : SZ_WORD;
			end
		end
	end

	// branch target uses the delay-slot address as base
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			br_valid_r <= 1'b0;
			br_taken_r <= 1'b0;
			br_target_r <= 32'h0;
		end else begin
			br_valid_r <= op_valid && op == OP_POS_BRANCH;
			br_taken_r <= op_valid && op == OP_POS_BRANCH && pos_r >= `POS_BRANCH_MIN;
			br_target_r <= pc + `BR_SLOT_BYTES + {{14{br_offset[15]}}, br_offset, 2'b00};
		end
	end

	// an instruction update wins over a same-cycle software write of the field
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pos_r <= `POS_RESET;
			scount_r <= `SCOUNT_RESET;
			carry_r <= 1'b0;
			ccond_r <= `CCOND_RESET;
		end else begin
			if (ctl_wr) begin
				pos_r <= ctl_wr_data[`CTL_POS_LSB+:`CTL_POS_W];
				scount_r <= ctl_wr_data[`CTL_SCOUNT_LSB+:`CTL_SCOUNT_W];
				carry_r <= ctl_wr_data[`CTL_CARRY_BIT];
				ccond_r <= ctl_wr_data[`CTL_CCOND_LSB+:`CTL_CCOND_W];
			end
			if (op_valid) begin
				case (op)
					OP_ADD_SET_C: carry_r <= csum[32];
					OP_PH_CMP: begin
						ccond_r[1] <= cmp_one(cmp_cond, {rs[31], rs[31:16]},
						                      {rt[31], rt[31:16]});
						ccond_r[0] <= cmp_one(cmp_cond, {rs[15], rs[15:0]},
						                      {rt[15], rt[15:0]});
					end
					OP_QB_CMP_CTL: ccond_r <= cmp_qb(cmp_cond, rs, rt);
					OP_FIELD_EXT_DEC: pos_r <= pos_r - fld_len;
					default: ;
				endcase
			end
		end
	end

	// one register bank per accumulator
	for (genvar g = 0; g < ACC_NUM; g++) begin : g_acc
		always_ff @(posedge clk_sys) begin
			if (!rstn)
				acc_r[g] <= `ACC_RESET;
			else if (acc_we && ac_sel == g)
				acc_r[g] <= acc_wval;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	abs_clamp_a: assert property (
		op_valid && op == OP_ABS_SAT && rt == `Q31_MIN && !ld_valid
		|=> gpr_we_r && gpr_wdata_r == `Q31_MAX)
		else $error("absolute value of most negative word not clamped");
	ph_lane_sat_a: assert property (
		op_valid && op == OP_PH_ADD_SAT && rs[31:16] == `Q15_MAX && rt[31:16] == 16'h0001
		&& !ld_valid |=> gpr_wdata_r[31:16] == `Q15_MAX)
		else $error("high halfword lane did not saturate");
	carry_chain_a: assert property (
		op_valid && op == OP_ADD_WITH_C && carry_r && !ld_valid
		|=> gpr_wdata_r == $past(rs) + $past(rt) + 32'h1)
		else $error("carry from previous add not included");
	byte_sat_a: assert property (
		op_valid && op == OP_QB_ADD_SAT && rs[31:24] == `UBYTE_MAX && rt[31:24] != 8'h00
		&& !ld_valid |=> gpr_wdata_r[31:24] == `UBYTE_MAX)
		else $error("byte lane wrapped instead of clamping");
	bit_mirror_a: assert property (
		op_valid && op == OP_BIT_REV && !ld_valid
		|=> gpr_wdata_r[31:16] == 16'h0 && gpr_wdata_r[15] == $past(rt[0])
		&& gpr_wdata_r[0] == $past(rt[15]))
		else $error("bit reversal result wrong");
	pos_branch_a: assert property (
		op_valid && op == OP_POS_BRANCH
		|=> br_valid_r && br_taken_r == ($past(pos_r) >= `POS_BRANCH_MIN))
		else $error("position branch decision wrong");
	cmp_reg_a: assert property (
		op_valid && op == OP_QB_CMP_REG && cmp_cond == CMP_EQ && !ld_valid
		|=> gpr_we_r && gpr_wdata_r[31:4] == 28'h0
		&& gpr_wdata_r[3] == ($past(rs[31:24]) == $past(rt[31:24])))
		else $error("byte compare to register wrong");
	cmp_ctl_a: assert property (
		op_valid && op == OP_QB_CMP_CTL && cmp_cond == CMP_LT
		|=> ccond_r[0] == ($past(rs[7:0]) < $past(rt[7:0]))
		&& ccond_r[1] == ($past(rs[15:8]) < $past(rt[15:8])))
		else $error("byte compare to control wrong");
	pos_walk_a: assert property (
		op_valid && op == OP_FIELD_EXT_DEC
		|=> pos_r == $past(pos_r) - {1'b0, $past(amt)} - 6'h01)
		else $error("position not lowered by field length");
	acc_fill_a: assert property (
		op_valid && op == OP_ACC_FILL && ac_sel == 0
		|=> lo_r == $past(rs) && hi_r == $past(lo_r))
		else $error("accumulator fill wrong");
	load_align_a: assert property (
		op_valid && op == OP_LOAD_WORD && ld_addr_nxt[1:0] != 2'h0
		|=> ld_align_err_r && !ld_req_r)
		else $error("misaligned word load issued");
	circ_wrap_a: assert property (
		op_valid && op == OP_CIRC_INDEX && rs == 32'h0 && !ld_valid
		|=> gpr_wdata_r == {8'h00, $past(rt[31:8])})
		else $error("circular index did not wrap to maximum");

	branch_taken_c: cover property (br_valid_r && br_taken_r);
	load_return_c: cover property (ld_req_r ##[1:8] ld_valid);
	acc_fill_c: cover property (op_valid && op == OP_ACC_FILL ##2 op_valid && op == OP_SHX_RND_SAT);
endmodule

// ===== sim/core_load_model.sv
// Purpose: core side load return for the extension datapath
// Assumes: one load outstanding, lat sets extra wait cycles
// Notes: data lines toggle between returns so stale data never looks valid
`timescale 1ns/1ps
module core_load_model (
	// clock and reset
	input  logic        clk_sys,
	input  logic        rstn,
	// request from the unit
	input  logic        ld_req_r,
	input  logic [31:0] ld_addr_r,
	input  logic [1:0]  lat,
	// return
	output logic        ld_valid,
	output logic [31:0] ld_data
);
	logic [31:0] addr_r;
	logic [2:0]  cnt_r;
	always_ff @(posedge clk_sys) begin
		ld_valid <= 1'b0;
		ld_data  <= ~ld_data;
		if (!rstn) begin
			cnt_r   <= 3'h0;
			ld_data <= 32'h0;
		end else if (ld_req_r) begin
			addr_r <= ld_addr_r;
			cnt_r  <= {1'b0, lat} + 3'h1;
		end else if (cnt_r == 3'h1) begin
			cnt_r    <= 3'h0;
			ld_valid <= 1'b1;
			ld_data  <= {16'h1234, 8'h80 | addr_r[15:8], 8'h80 | addr_r[7:0]};
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule

// ===== sim/dsp_simd_execution_unit_bench.sv
// Purpose: self-checking bench of the extension datapath
// Assumes: one op at a time, results read one cycle after issue
// Notes: accumulators are preset with fill so every sum starts known
`timescale 1ns/1ps
module dsp_simd_execution_unit_bench;
	import dsp_pkg::*;
	logic clk_sys = 0, rstn = 0, op_valid = 0, amt_from_reg = 0, ctl_wr = 0;
	op_t op = OP_ABS_SAT;
	cmp_cond_t cmp_cond = CMP_EQ;
	logic [31:0] rs = 0, rt = 0, ctl_wr_data = 0, ld_data, ld_addr_r, gpr_wdata_r, br_target_r;
	logic [31:0] hi_r, lo_r;
	logic [4:0]  imm_amt = 0, gpr_waddr_r;
	logic [1:0]  ac_sel = 0, lat = 0;
	logic [5:0]  pos_r, scount_r;
	ld_size_t    ld_size_r;
	logic [3:0]  ccond_r;
	logic ld_valid, gpr_we_r, br_valid_r, br_taken_r, ld_req_r, ld_align_err_r, carry_r;
	int mismatches = 0, n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	dsp_simd_execution_unit #(.ACC_NUM(4)) dut (.clk_sys(clk_sys), .rstn(rstn),
		.op_valid(op_valid), .op(op), .cmp_cond(cmp_cond), .rs(rs), .rt(rt),
		.rd_idx(5'h0B), .ac_sel(ac_sel), .imm_amt(imm_amt), .amt_from_reg(amt_from_reg),
		.pc(32'h00001000), .br_offset(16'hFFFE), .ctl_wr(ctl_wr), .ctl_wr_data(ctl_wr_data),
		.ld_valid(ld_valid), .ld_data(ld_data), .gpr_we_r(gpr_we_r), .gpr_waddr_r(gpr_waddr_r),
		.gpr_wdata_r(gpr_wdata_r), .br_valid_r(br_valid_r), .br_taken_r(br_taken_r),
		.br_target_r(br_target_r), .ld_req_r(ld_req_r), .ld_addr_r(ld_addr_r),
		.ld_size_r(ld_size_r), .ld_align_err_r(ld_align_err_r), .pos_r(pos_r),
		.scount_r(scount_r), .carry_r(carry_r),
		.ccond_r(ccond_r), .hi_r(hi_r), .lo_r(lo_r));
	core_load_model mem (.clk_sys(clk_sys), .rstn(rstn), .ld_req_r(ld_req_r),
		.ld_addr_r(ld_addr_r), .lat(lat), .ld_valid(ld_valid), .ld_data(ld_data));
	task automatic ck(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// m[5] picks the register amount, m[4:0] is the immediate
	task automatic iss(input op_t o, input logic [31:0] a, input logic [31:0] b,
		input logic [5:0] m = 6'h00, input cmp_cond_t c = CMP_EQ, input logic [1:0] s = 2'h0);
		@(posedge clk_sys);
		op_valid <= 1'b1;
		op <= o;
		rs <= a;
		rt <= b;
		amt_from_reg <= m[5];
		imm_amt <= m[4:0];
		cmp_cond <= c;
		ac_sel <= s;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		#1;
	endtask
	task automatic ctl(input logic [31:0] d);
		@(posedge clk_sys);
		ctl_wr <= 1'b1;
		ctl_wr_data <= d;
		@(posedge clk_sys);
		ctl_wr <= 1'b0;
		#1;
	endtask
	task automatic fill(input logic [31:0] h, input logic [31:0] l);
		iss(OP_ACC_FILL, h, h);
		iss(OP_ACC_FILL, l, l);
		ck({hi_r, lo_r}, {h, l});
	endtask
	task automatic t_arith;
		iss(OP_ABS_SAT, 32'h80000000, 32'h80000000);
		ck({gpr_we_r, gpr_waddr_r, gpr_wdata_r}, {6'h2B, 32'h7FFFFFFF});
		iss(OP_PH_ADD, 32'h7FFF0001, 32'h0001FFFF);
		ck(gpr_wdata_r, 32'h80000000);
		iss(OP_PH_ADD_SAT, 32'h7FFF0001, 32'h0001FFFF);
		ck(gpr_wdata_r, 32'h7FFF0000);
		iss(OP_W_ADD_SAT, 32'h80000000, 32'hFFFFFFFF);
		ck(gpr_wdata_r, 32'h80000000);
		iss(OP_ADD_SET_C, 32'hFFFFFFFF, 32'h00000002);
		ck({carry_r, gpr_wdata_r}, 33'h100000001);
		iss(OP_ADD_WITH_C, 32'h00000001, 32'h00000002);
		ck(gpr_wdata_r, 32'h00000004);
		iss(OP_QB_ADD, 32'hFF018010, 32'h010180F0);
		ck(gpr_wdata_r, 32'h00020000);
		iss(OP_QB_ADD_SAT, 32'hFF018010, 32'h010180F0);
		ck(gpr_wdata_r, 32'hFF02FFFF);
		iss(OP_BIT_REV, 32'hFFFF0003, 32'hFFFF0003);
		ck(gpr_wdata_r, 32'h0000C000);
		iss(OP_CIRC_INDEX, 32'h00000000, 32'h00010004);
		ck(gpr_wdata_r, 32'h00000100);
		iss(OP_CIRC_INDEX, 32'h00000010, 32'h00010004);
		ck(gpr_wdata_r, 32'h0000000C);
		iss(OP_BH_MUL_L, 32'hFF020000, 32'hFFFF0003);
		ck(gpr_wdata_r, 32'hFFFF0006);
		iss(OP_BH_MUL_R, 32'h0000FF02, 32'hFFFF0003);
		ck(gpr_wdata_r, 32'hFFFF0006);
	endtask
	task automatic t_cmp_branch;
		logic [1:0] ph [3] = '{2'b10, 2'b01, 2'b11};
		logic [3:0] qb [3] = '{4'b1001, 4'b0010, 4'b1011};
		for (int i = 0; i < 3; i++) begin
			iss(OP_PH_CMP, 32'h0001FFFF, 32'h00010000, 6'h00, cmp_cond_t'(i));
			ck(ccond_r[1:0], ph[i]);
			iss(OP_QB_CMP_REG, 32'h01FF0500, 32'h01000600, 6'h00, cmp_cond_t'(i));
			ck(gpr_wdata_r, {28'h0, qb[i]});
			iss(OP_QB_CMP_CTL, 32'h01FF0500, 32'h01000600, 6'h00, cmp_cond_t'(i));
			ck({gpr_we_r, ccond_r}, {1'b0, qb[i]});
		end
		ctl(32'h00000020);
		iss(OP_POS_BRANCH, 32'h0, 32'h0);
		ck({br_valid_r, br_taken_r, br_target_r}, {2'b11, 32'h00000FFC});
		ctl(32'h0000001F);
		iss(OP_POS_BRANCH, 32'h0, 32'h0);
		ck({br_valid_r, br_taken_r}, 2'b10);
	endtask
	task automatic t_mac;
		fill(32'h0, 32'h0);
		iss(OP_DOT_FRAC_ADD, 32'h80008000, 32'h80008000);
		ck({hi_r, lo_r}, 64'h000000007FFFFFFF);
		iss(OP_DOT_FRAC_SUB, 32'h80008000, 32'h80008000);
		ck({hi_r, lo_r}, 64'h0);
		iss(OP_DOT_BYTE_ADD_L, 32'h03020000, 32'h05040000);
		iss(OP_DOT_BYTE_ADD_R, 32'h00000302, 32'h00000504);
		ck(lo_r, 32'h0000002E);
		iss(OP_DOT_BYTE_SUB_L, 32'h03020000, 32'h05040000);
		ck(lo_r, 32'h00000017);
		iss(OP_DOT_BYTE_SUB_R, 32'h00000302, 32'h00000504);
		iss(OP_WORD_FRAC_MSUB, 32'h80000000, 32'h80000000);
		ck({hi_r, lo_r}, 64'h8000000000000001);
		fill(32'h0, 32'h0);
		iss(OP_LANE_MAC_L, 32'h40000000, 32'h40000000);
		iss(OP_LANE_MAC_R, 32'h00004000, 32'h00004000);
		ck(lo_r, 32'h40000000);
		fill(32'h0, 32'h7FFFFFF0);
		iss(OP_LANE_MAC_SAT_L, 32'h40000000, 32'h40000000);
		ck({hi_r, lo_r}, 64'h000000007FFFFFFF);
		// a fill of another accumulator must leave the hi/lo pair alone
		iss(OP_ACC_FILL, 32'h5, 32'h5, 6'h00, CMP_EQ, 2'h1);
		ck({hi_r, lo_r}, 64'h000000007FFFFFFF);
		// negative side of the clamp
		fill(32'hFFFFFFFF, 32'h80000010);
		iss(OP_LANE_MAC_SAT_R, 32'h00008000, 32'h00004000);
		ck({hi_r, lo_r}, 64'hFFFFFFFF80000000);
	endtask
	task automatic t_extract;
		fill(32'h0, 32'h0000ABCD);
		ctl(32'h0000000F);
		iss(OP_FIELD_EXT, 32'h0, 32'h0, 6'h07);
		ck({pos_r, gpr_wdata_r}, {6'h0F, 32'h000000AB});
		iss(OP_FIELD_EXT_DEC, 32'h7, 32'h0, 6'h20);
		ck({pos_r, gpr_wdata_r}, {6'h07, 32'h000000AB});
		iss(OP_FIELD_EXT_DEC, 32'h0, 32'h0, 6'h07);
		ck(gpr_wdata_r, 32'h000000CD);
		iss(OP_SHX, 32'h0, 32'h0, 6'h04);
		ck(gpr_wdata_r, 32'h00000ABC);
		iss(OP_SHX_RND, 32'h0, 32'h0, 6'h04);
		ck(gpr_wdata_r, 32'h00000ABD);
		fill(32'h1, 32'h0);
		iss(OP_SHX_RND_SAT, 32'h0, 32'h0, 6'h00);
		ck(gpr_wdata_r, 32'h7FFFFFFF);
		iss(OP_SHX, 32'h4, 32'h0, 6'h20);
		ck(gpr_wdata_r, 32'h10000000);
		fill(32'h0, 32'h00ABCDEF);
		iss(OP_SHX_HALF, 32'h0, 32'h0, 6'h04);
		ck(gpr_wdata_r, 32'h00007FFF);
		ctl(32'h00000108);
		ck({pos_r, scount_r}, {6'h08, 6'h04});
		iss(OP_FIELD_INS, 32'h0, 32'hFFFFFFFF);
		ck(gpr_wdata_r, 32'hFFFFF0FF);
	endtask
	task automatic ld(input op_t o, input logic [31:0] idx, input logic [31:0] exp,
		input ld_size_t sz);
		int k = 0;
		iss(o, 32'h00000100, idx);
		ck({ld_req_r, ld_addr_r}, {1'b1, 32'h100 + idx});
		ck(ld_size_r, sz);
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (gpr_we_r !== 1'b1 && k < 20);
		ck({gpr_we_r, gpr_wdata_r}, {1'b1, exp});
	endtask
	task automatic t_load;
		ld(OP_LOAD_HALF, 32'h2, 32'hFFFF8182, SZ_HALF);
		lat = 2'h3;
		ld(OP_LOAD_BYTE, 32'h3, 32'h00000083, SZ_BYTE);
		ld(OP_LOAD_WORD, 32'h4, 32'h12348184, SZ_WORD);
		iss(OP_LOAD_WORD, 32'h00000100, 32'h2);
		ck({ld_align_err_r, ld_req_r}, 2'b10);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		ck({hi_r, lo_r}, 64'h0);
		ck({pos_r, scount_r, carry_r, ccond_r}, 17'h0);
		ck(ld_size_r, SZ_WORD);
		t_arith;
		t_cmp_branch;
		t_mac;
		t_extract;
		t_load;
		finish_test;
	end
endmodule
